// ### src/sync_tx.sv
/*
  Synchronous master transmit path of a serial port: register port,
  baud generator, transmit buffer, shift register and pin drivers.
  Assumes a same-clock register master and a receive path that reports
  the end of a single-word reception by a one-cycle pulse.
*/
`timescale 1ns/100ps

// Function
// R1 - Transmission pauses while any reception is enabled; half duplex.
// R2 - Clocked mode plus port enable turn pins into clock and data lines.
// R3 - Clock source select set makes the block drive the clock line.
// R4 - Shift register reloads only after last bit, and only if buffer full.
// R5 - Buffer to shifter move takes one cycle, then buffer-empty flag sets.
// R6 - Buffer-empty flag ignores enable; only a buffer write clears it.
// R7 - Read-only shifter-empty flag, polled, set while shifter empty.
// R8 - Transmit enable allows sending; shifting waits for buffer data.
// R9 - Bits change on rising clock edge, stable around falling edge.
// R10 - Baud generator held in reset while all three enables clear.
// R11 - Buffer written before enabling starts once enable is set.
// R12 - Empty shifter takes a buffer write at once; words go back to back.
// R13 - Clearing transmit enable aborts, resets transmitter, floats pins.
// R14 - Reception enable aborts, floats data, keeps clock, keeps state.
// R15 - Single reception done clears its enable; sending resumes at once.
// R16 - Ninth bit sampled from ninth data bit at the buffer transfer.
// R17 - Software writes the ninth bit before the buffer.
// R18 - Software sets divisor, mode, enables, ninth bit, then buffer.
// R19 - Software sets global and peripheral interrupt enables elsewhere.
// R20 - Shift register is not reachable from the register port.
// R21 - Least significant bit first, ninth bit last.
module sync_tx #(
  parameter int DIV_W = 8
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       rx_word_done,
  output logic            shift_strobe_out,
  output logic            shift_strobe_oe_n,
  output logic            serial_data_out,
  output logic            serial_data_oe_n
);

  // Divisor register is one byte wide at most
  generate
    if (DIV_W < 1 || DIV_W > 8) begin : g_bad_width
      $error("DIV_W must lie between 1 and 8");
    end
  endgenerate

  // Software-visible state
  logic [7:0]             tx_ctrl;
  logic [7:0]             rx_ctrl;
  logic [7:0]             tx_buffer;
  logic                   buffer_full;
  logic [DIV_W-1:0]       baud_divisor;
  logic                   tx_flag;
  logic                   tx_irq_enable;
  logic [7:0]             next_tx_ctrl;
  logic [7:0]             next_rx_ctrl;
  logic [7:0]             next_tx_buffer;
  logic                   next_buffer_full;
  logic [DIV_W-1:0]       next_baud_divisor;
  logic                   next_tx_flag;
  logic                   next_tx_irq_enable;
  logic [7:0]             next_reg_rdata;

  // Transmitter engine state
  sync_tx_pkg::tx_state_t state;
  sync_tx_pkg::tx_state_t next_state;
  logic [8:0]             shifter;
  logic [8:0]             next_shifter;
  logic [3:0]             bits_left;
  logic [3:0]             next_bits_left;
  logic [DIV_W-1:0]       baud_count;
  logic [DIV_W-1:0]       next_baud_count;
  logic                   clk_level;
  logic                   next_clk_level;
  logic                   data_bit;
  logic                   next_data_bit;
  logic                   next_strobe_oe_n;
  logic                   next_data_oe_n;

  // Decoded controls
  logic tx_enable;
  logic rx_active;
  logic port_on;
  logic brg_run;
  logic baud_tick;
  logic buf_write;
  logic transfer;

  // Index match used only by the buffer-write decode
  function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
    hit = (a == idx);
  endfunction : hit

  // Mode decode and one-cycle baud tick
  assign tx_enable = tx_ctrl[sync_tx_pkg::BIT_TX_ENABLE];
  assign rx_active = rx_ctrl[sync_tx_pkg::BIT_CONT_RX] | rx_ctrl[sync_tx_pkg::BIT_SINGLE_RX];
  assign port_on   = tx_ctrl[sync_tx_pkg::BIT_CLOCKED_MODE] &
                     rx_ctrl[sync_tx_pkg::BIT_PORT_ENABLE]; // [R2]
  assign brg_run   = tx_enable | rx_active; // [R10]
  assign baud_tick = brg_run && (baud_count == '0);
  assign buf_write = reg_wr && hit(reg_addr, sync_tx_pkg::ADDR_TRANSMIT_BUFFER);
  // Move waits a cycle behind a buffer write so the flag never races it
  assign transfer  = (state == sync_tx_pkg::ST_EMPTY) && buffer_full && tx_enable &&
                     !rx_active && !buf_write; // [R4] [R8] [R11] [R1]

  // Register port, buffer and flag next values
  always_comb begin
    next_tx_ctrl       = tx_ctrl;
    next_rx_ctrl       = rx_ctrl;
    next_tx_buffer     = tx_buffer;
    next_buffer_full   = buffer_full;
    next_baud_divisor  = baud_divisor;
    next_tx_flag       = tx_flag;
    next_tx_irq_enable = tx_irq_enable;
    next_reg_rdata     = sync_tx_pkg::RESET_BYTE;
    // Software writes land whole; hardware terms below override them
    if (reg_wr) begin
      case (reg_addr)
        sync_tx_pkg::ADDR_TX_STATUS_CONTROL: begin
          next_tx_ctrl = reg_wdata;
        end
        sync_tx_pkg::ADDR_RX_STATUS_CONTROL: begin
          next_rx_ctrl = reg_wdata;
        end
        sync_tx_pkg::ADDR_TRANSMIT_BUFFER: begin
          next_tx_buffer   = reg_wdata;
          next_buffer_full = 1'b1;
          next_tx_flag     = 1'b0; // [R6]
        end
        sync_tx_pkg::ADDR_BAUD_DIVISOR: begin
          next_baud_divisor = reg_wdata[DIV_W-1:0];
        end
        sync_tx_pkg::ADDR_PERIPH_ENABLES: begin
          next_tx_irq_enable = reg_wdata[sync_tx_pkg::BIT_TX_FLAG];
        end
        default: begin
        end
      endcase
    end
    // Read-only and unused control bits never keep a written one
    next_tx_ctrl = next_tx_ctrl & sync_tx_pkg::TX_CTRL_WRITABLE;
    next_rx_ctrl = next_rx_ctrl & sync_tx_pkg::RX_CTRL_WRITABLE;
    // Receive path ends a single reception; write cannot override it
    if (rx_word_done) begin
      next_rx_ctrl[sync_tx_pkg::BIT_SINGLE_RX] = 1'b0; // [R15]
    end
    // Enabling with an empty buffer reports empty at once
    if (!tx_enable && next_tx_ctrl[sync_tx_pkg::BIT_TX_ENABLE] && !buffer_full) begin
      next_tx_flag = 1'b1;
    end
    // Transfer empties the buffer; a buffer write never meets it
    if (transfer) begin
      next_buffer_full = 1'b0;
      next_tx_flag     = 1'b1; // [R5] [R6]
    end
    // Read image registered for the cycle after the strobe only
    if (reg_rd) begin
      case (reg_addr)
        sync_tx_pkg::ADDR_TX_STATUS_CONTROL: begin
          next_reg_rdata = tx_ctrl;
          next_reg_rdata[sync_tx_pkg::BIT_SHIFTER_EMPTY] =
            (state == sync_tx_pkg::ST_EMPTY); // [R7]
        end
        sync_tx_pkg::ADDR_RX_STATUS_CONTROL: begin
          next_reg_rdata = rx_ctrl;
        end
        sync_tx_pkg::ADDR_TRANSMIT_BUFFER: begin
          next_reg_rdata = tx_buffer; // [R20]
        end
        sync_tx_pkg::ADDR_BAUD_DIVISOR: begin
          next_reg_rdata[DIV_W-1:0] = baud_divisor;
        end
        sync_tx_pkg::ADDR_PERIPH_FLAGS_ONE: begin
          next_reg_rdata[sync_tx_pkg::BIT_TX_FLAG] = tx_flag;
        end
        sync_tx_pkg::ADDR_PERIPH_ENABLES: begin
          next_reg_rdata[sync_tx_pkg::BIT_TX_FLAG] = tx_irq_enable;
        end
        default: begin
        end
      endcase
    end
  end

  // Register state
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_ctrl       <= sync_tx_pkg::RESET_BYTE;
      rx_ctrl       <= sync_tx_pkg::RESET_BYTE;
      tx_buffer     <= sync_tx_pkg::RESET_BYTE;
      buffer_full   <= 1'b0;
      baud_divisor  <= '0;
      tx_flag       <= 1'b0;
      tx_irq_enable <= 1'b0;
      reg_rdata     <= sync_tx_pkg::RESET_BYTE;
    end else begin
      tx_ctrl       <= next_tx_ctrl;
      rx_ctrl       <= next_rx_ctrl;
      tx_buffer     <= next_tx_buffer;
      buffer_full   <= next_buffer_full;
      baud_divisor  <= next_baud_divisor;
      tx_flag       <= next_tx_flag;
      tx_irq_enable <= next_tx_irq_enable;
      reg_rdata     <= next_reg_rdata;
    end
  end

  // Baud generator, shifter and pin drivers next values
  always_comb begin
    next_state      = state;
    next_shifter    = shifter;
    next_bits_left  = bits_left;
    next_clk_level  = clk_level;
    next_data_bit   = data_bit;
    next_baud_count = baud_count;
    // Half-period counter, reloaded from the divisor
    if (!brg_run) begin
      next_baud_count = '0; // [R10]
    end else if (baud_tick) begin
      next_baud_count = baud_divisor;
    end else begin
      next_baud_count = baud_count - 1'b1;
    end
    // Load a word; the ninth bit is the one standing now
    if (transfer) begin
      next_state     = sync_tx_pkg::ST_LOADED;
      next_shifter   = {tx_ctrl[sync_tx_pkg::BIT_NINTH_DATA], tx_buffer}; // [R16]
      next_bits_left = tx_ctrl[sync_tx_pkg::BIT_NINTH_ENABLE] ?
                       sync_tx_pkg::BITS_NINE : sync_tx_pkg::BITS_EIGHT;
    end
    // Reception owns the clock while enabled
    if (baud_tick && rx_active) begin
      // Clock keeps running for the receiver; shifter frozen
      next_clk_level = !clk_level; // [R14]
    end else if (baud_tick && state == sync_tx_pkg::ST_LOADED) begin
      next_clk_level = !clk_level;
      // Word ends on the tick after its last bit; a fall lost to a
      // reception must not start a rise with nothing left to send
      if (bits_left == '0) begin
        next_state     = sync_tx_pkg::ST_EMPTY; // [R4] [R12]
        next_clk_level = 1'b0;
      end else if (!clk_level) begin
        next_data_bit  = shifter[0]; // [R9] [R21]
        next_shifter   = {1'b0, shifter[8:1]};
        next_bits_left = bits_left - 1'b1;
      end
    end
    // Idle clock sits low so the first edge after a load is a rise
    if (!rx_active && state == sync_tx_pkg::ST_EMPTY && !transfer) begin
      next_clk_level = 1'b0;
    end
    // Disable resets the engine; buffer and flag survive
    if (!tx_enable) begin
      next_state     = sync_tx_pkg::ST_EMPTY; // [R13]
      next_bits_left = '0;
      next_shifter   = '0;
      if (!rx_active) begin
        next_clk_level = 1'b0;
      end
    end
    // Pin enables: clock while master and any enable, data while transmit enabled and no reception
    next_strobe_oe_n = !(port_on && tx_ctrl[sync_tx_pkg::BIT_CLOCK_SOURCE] &&
                         brg_run); // [R3] [R13] [R14]
    next_data_oe_n   = !(port_on && tx_enable && !rx_active); // [R1] [R13] [R15]
  end

  // Engine and pin registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state             <= sync_tx_pkg::ST_EMPTY;
      shifter           <= '0;
      bits_left         <= '0;
      baud_count        <= '0;
      clk_level         <= 1'b0;
      data_bit          <= 1'b0;
      shift_strobe_out  <= 1'b0;
      shift_strobe_oe_n <= 1'b1;
      serial_data_out   <= 1'b0;
      serial_data_oe_n  <= 1'b1;
    end else begin
      state             <= next_state;
      shifter           <= next_shifter;
      bits_left         <= next_bits_left;
      baud_count        <= next_baud_count;
      clk_level         <= next_clk_level;
      data_bit          <= next_data_bit;
      shift_strobe_out  <= next_clk_level;
      shift_strobe_oe_n <= next_strobe_oe_n;
      serial_data_out   <= next_data_bit;
      serial_data_oe_n  <= next_data_oe_n;
    end
  end

endmodule : sync_tx

// ### include/sync_tx_pkg.sv
/*
  Constants for the synchronous master transmitter: register indices,
  bit positions, reset values and transmitter states.
  Assumes a byte-wide register port with a three-bit word address.
*/
package sync_tx_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] ADDR_TX_STATUS_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_RX_STATUS_CONTROL = 3'h1;
  localparam logic [2:0] ADDR_TRANSMIT_BUFFER   = 3'h2;
  localparam logic [2:0] ADDR_BAUD_DIVISOR      = 3'h3;
  localparam logic [2:0] ADDR_PERIPH_FLAGS_ONE  = 3'h4;
  localparam logic [2:0] ADDR_PERIPH_ENABLES    = 3'h5;

  // Bits of transmit_status_control
  localparam int BIT_CLOCK_SOURCE  = 7;
  localparam int BIT_NINTH_ENABLE  = 6;
  localparam int BIT_TX_ENABLE     = 5;
  localparam int BIT_CLOCKED_MODE  = 4;
  localparam int BIT_SHIFTER_EMPTY = 1;
  localparam int BIT_NINTH_DATA    = 0;

  // Bits of receive_status_control
  localparam int BIT_PORT_ENABLE   = 7;
  localparam int BIT_SINGLE_RX     = 5;
  localparam int BIT_CONT_RX       = 4;

  // Buffer-empty flag and its enable share one position
  localparam int BIT_TX_FLAG       = 4;

  // Word lengths in bits
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE  = 4'h9;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Control bits that software may hold; the others never keep a write
  localparam logic [7:0] TX_CTRL_WRITABLE = 8'hf1;
  localparam logic [7:0] RX_CTRL_WRITABLE = 8'hb0;

  // Transmit shift register occupancy, one-hot
  typedef enum logic [1:0] {
    ST_EMPTY  = 2'b01,
    ST_LOADED = 2'b10
  } tx_state_t;

endpackage : sync_tx_pkg

// ### test/sync_tx_assertions.sv
/*
  Port checker for the synchronous transmitter.
  Assumes binding into every sync_tx instance.
*/
`timescale 1ns/100ps
module sync_tx_assertions (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       rx_word_done,
  input wire logic       shift_strobe_out,
  input wire logic       shift_strobe_oe_n,
  input wire logic       serial_data_out,
  input wire logic       serial_data_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Control writes and the buffer-write, flag-read pair
  sequence tx_wr_s;
    reg_wr && reg_addr == sync_tx_pkg::ADDR_TX_STATUS_CONTROL;
  endsequence
  sequence rx_wr_s;
    reg_wr && reg_addr == sync_tx_pkg::ADDR_RX_STATUS_CONTROL;
  endsequence
  sequence buf_flag_s;
    reg_wr && reg_addr == sync_tx_pkg::ADDR_TRANSMIT_BUFFER
    ##1 reg_rd && reg_addr == sync_tx_pkg::ADDR_PERIPH_FLAGS_ONE;
  endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  tx_off_a: assert property (tx_wr_s ##0 !reg_wdata[5] |->
    ##[1:3] (shift_strobe_oe_n && serial_data_oe_n && !shift_strobe_out))
    else $error("pins not released after disable");
  rx_float_a: assert property (rx_wr_s ##0 (reg_wdata[5] || reg_wdata[4]) |->
    ##[1:3] serial_data_oe_n) else $error("data still driven in reception");
  port_off_a: assert property (rx_wr_s ##0 !reg_wdata[7] |->
    ##[1:3] (shift_strobe_oe_n && serial_data_oe_n)) else $error("pins driven with port off");
  data_fall_a: assert property ($fell(shift_strobe_out) && !serial_data_oe_n |->
    $stable(serial_data_out)) else $error("data moved at falling edge");
  data_rise_a: assert property (!serial_data_oe_n && $past(!serial_data_oe_n)
    && $changed(serial_data_out) |-> $rose(shift_strobe_out)) else $error("data off rising edge");
  strobe_drv_a: assert property ($rose(shift_strobe_out) |-> !shift_strobe_oe_n)
    else $error("clock toggles undriven");
  flag_clear_a: assert property (buf_flag_s |=> !reg_rdata[4])
    else $error("flag set after buffer write");
endmodule : sync_tx_assertions
bind sync_tx sync_tx_assertions i_sync_tx_assertions (.*);

// ### test/sync_slave_model.sv
/*
  External synchronous slave: samples data at falling clock edges.
  Assumes pin levels resolved by the bench, clock line pulled low.
*/
`timescale 1ns/100ps
module sync_slave_model (
  input  wire logic        sys_clk,
  input  wire logic        clr,
  input  wire logic        strobe_line,
  input  wire logic        data_line,
  output logic      [31:0] got,
  output logic      [5:0]  got_count
);
  logic last_strobe;
  // New bits enter at the top, so the first bit ends lowest
  always @(posedge sys_clk) begin
    last_strobe <= strobe_line;
    if (clr) begin
      got_count <= 6'h00;
    end else if (last_strobe && !strobe_line) begin
      got <= {data_line, got[31:1]};
      got_count <= got_count + 6'h01;
    end
  end
endmodule : sync_slave_model

// ### test/usart_sync_master_transmitter_bench.sv
/*
  Bench for the synchronous transmitter: register port, pins, slave.
  Assumes the checker bound into sync_tx.
*/
`timescale 1ns/100ps
module usart_sync_master_transmitter_bench;
  localparam logic [2:0] A_TX  = sync_tx_pkg::ADDR_TX_STATUS_CONTROL;
  localparam logic [2:0] A_RX  = sync_tx_pkg::ADDR_RX_STATUS_CONTROL;
  localparam logic [2:0] A_BUF = sync_tx_pkg::ADDR_TRANSMIT_BUFFER;
  localparam logic [2:0] A_FLG = sync_tx_pkg::ADDR_PERIPH_FLAGS_ONE;
  logic        sys_clk, rst_b, reg_wr, reg_rd, rx_word_done, clr, last_dt, n9;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, b, b2;
  logic        strobe_q, strobe_oe_n, data_q, data_oe_n;
  logic [31:0] got;
  logic [5:0]  got_count;
  int          err_count, num_checks, cycles, seed, i, k;
  // Clock pulled low when released, data floats to the inverse
  wire strobe_line = strobe_oe_n ? 1'b0 : strobe_q;
  wire data_line   = data_oe_n ? ~last_dt : data_q;
  sync_tx #(.DIV_W(8)) i_sync_tx (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_word_done(rx_word_done), .shift_strobe_out(strobe_q), .shift_strobe_oe_n(strobe_oe_n),
    .serial_data_out(data_q), .serial_data_oe_n(data_oe_n));
  sync_slave_model i_sync_slave_model (.sys_clk(sys_clk), .clr(clr), .strobe_line(strobe_line),
    .data_line(data_line), .got(got), .got_count(got_count));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Floating pattern and hang guard
  always @(posedge sys_clk) begin
    last_dt <= data_line;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      $display("FAIL %0t run timed out", $time);
      summarize();
    end
  end
  function automatic logic [31:0] frame(input logic [7:0] d, input logic top);
    return {23'h0, top, d};
  endfunction : frame
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    num_checks++;
    if (v !== e) begin
      err_count++;
      $display("FAIL %0t got %h expected %h", $time, v, e);
    end
  endtask : chk
  task automatic wr0(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr0
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    wr0(a, d);
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge sys_clk);
  endtask : rd
  task automatic bits(input logic [5:0] n);
    for (int j = 0; j < 4000 && got_count < n; j++) @(posedge sys_clk);
    if (got_count < n) begin
      err_count++;
      $display("FAIL %0t slave saw too few bits", $time);
    end
  endtask : bits
  task automatic fresh();
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
  endtask : fresh
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    {reg_wr, reg_rd, rx_word_done, reg_addr, reg_wdata, last_dt} = '0;
    {rst_b, cycles, err_count, num_checks} = '0;
    clr = 1'b1;
    seed = 32'h94fe;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    clr <= 1'b0;
    for (i = 0; i < 8; i++) rd(3'(i), i == 0 ? 8'h02 : 8'h00);
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h00);
    // Divisor 9 gives a 160 ns clock
    wr(sync_tx_pkg::ADDR_BAUD_DIVISOR, 8'h09);
    rd(sync_tx_pkg::ADDR_BAUD_DIVISOR, 8'h09);
    wr(sync_tx_pkg::ADDR_PERIPH_ENABLES, 8'h10);
    rd(sync_tx_pkg::ADDR_PERIPH_ENABLES, 8'h10);
    wr(A_RX, 8'h80);
    wr(A_TX, 8'hb0);
    rd(A_FLG, 8'h10);
    wr(A_FLG, 8'h00);
    rd(A_FLG, 8'h10);
    // Nine-bit words; the ninth bit changes just after transfer
    for (i = 0; i < 3; i++) begin
      b = (i == 0) ? 8'hff : 8'($random(seed));
      n9 = 1'($random(seed));
      wr(A_TX, {7'h78, n9});
      fresh();
      wr(A_BUF, b);
      wr(A_TX, {7'h78, ~n9});
      bits(6'h09);
      chk(got >> 23, frame(b, n9));
      rd(A_TX, {7'h79, ~n9});
    end
    // Back-to-back eight-bit words
    wr(A_TX, 8'hb0);
    fresh();
    b = 8'h01;
    b2 = 8'($random(seed));
    wr(A_BUF, b);
    wr0(A_BUF, b2);
    rd(A_FLG, 8'h00);
    rd(A_TX, 8'hb0);
    @(posedge strobe_q);
    for (k = 0; strobe_q === 1'b1 && k < 50; k++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(k, 32'h0a);
    bits(6'h10);
    chk(got >> 16, {16'h0, b2, b});
    rd(A_FLG, 8'h10);
    rd(A_BUF, b2);
    // Abort by disable, then buffer first and enable after
    fresh();
    wr(A_BUF, 8'h5a);
    bits(6'h03);
    wr(A_TX, 8'h90);
    repeat (2) @(posedge sys_clk);
    #1 chk({strobe_oe_n, data_oe_n, strobe_q}, 3'b110);
    @(posedge sys_clk);
    rd(A_TX, 8'h92);
    fresh();
    b = 8'($random(seed));
    wr(A_BUF, b);
    rd(A_FLG, 8'h00);
    wr(A_TX, 8'hb0);
    bits(6'h08);
    chk(got >> 24, b);
    // Single and continuous reception during a word
    for (k = 0; k < 2; k++) begin
      fresh();
      wr(A_BUF, 8'h3c);
      bits(6'h02);
      wr(A_RX, k ? 8'h90 : 8'ha0);
      repeat (2) @(posedge sys_clk);
      #1 chk({data_oe_n, strobe_oe_n}, 2'b10);
      @(posedge sys_clk);
      if (k) wr(A_RX, 8'h80);
      else begin
        rx_word_done <= 1'b1;
        @(posedge sys_clk);
        rx_word_done <= 1'b0;
      end
      rd(A_RX, 8'h80);
      chk(data_oe_n, 1'b0);
      wr(A_TX, 8'h90);
      wr(A_TX, 8'hb0);
    end
    wr(A_RX, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 chk({strobe_oe_n, data_oe_n}, 2'b11);
    summarize();
  end
endmodule : usart_sync_master_transmitter_bench
